// [psc_controller.sv]
// Purpose: closed-loop set point controller for a speed drive
// Assumes: AXI4-Lite register access, 12-bit feedback converters
// Notes: speed command is a 12-bit fraction of maximum speed
// What this block does
// - loop off bypasses controller, open loop
// - normal mode: rising feedback lowers speed
// - reverse mode: rising feedback raises speed
// - remote auto: analog or keypad set point
// - local auto: keypad set point only
// - manual with loop on: keypad speed
// - loop off: keypad, analog or preset
// - feedback from voltage or current input
// - minimum signal maps to low value
// - maximum signal maps to high value
// - proportional term is gain times error
// - integral rises at gain times error
// - derivative is gain times error slope
// - set point ramps; zero rate disables
// - low alarm when signal below setting
// - high alarm when signal above setting
// - current input lost below 2 mA
`timescale 1ns/1ps
`default_nettype none
module psc_controller #(
   parameter int SAMPLE_CYCLES = psc_pkg::SAMPLE_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [11:0] voltage_input,
   input wire logic [11:0] current_input,
   output logic [11:0] speed_cmd,
   output psc_pkg::psc_src_t speed_source,
   output logic closed_loop,
   output logic low_level_alarm,
   output logic high_level_alarm,
   output logic current_input_lost
);
   import psc_pkg::*;

   logic [11:0] volt_s, cur_s;
   logic [8:0] ctrl;
   logic signed [15:0] fb_low, fb_high, alarm_low, alarm_high, pv;
   logic [15:0] kp, ki, kd;
   logic [11:0] ramp_rate, key_sp, key_speed, preset_speed;
   logic [7:0] aw_addr;
   logic [31:0] w_data, wr_val;
   logic [3:0] w_strb;
   logic do_write;

   ////////////////////////////////////////////////////////////////////////
   // converter inputs come from pins
   psc_sync #(.W(ADC_W)) u_sync_volt (.aclk(aclk), .aresetn(aresetn),
      .d(voltage_input), .q(volt_s));
   psc_sync #(.W(ADC_W)) u_sync_cur (.aclk(aclk), .aresetn(aresetn),
      .d(current_input), .q(cur_s));

   ////////////////////////////////////////////////////////////////////////
   // register view and write merge
   function automatic logic [31:0] reg_view(input logic [7:0] a);
      case (a)
         REG_CTRL: reg_view = {23'h0, ctrl};
         REG_FB_LOW: reg_view = {16'h0, fb_low};
         REG_FB_HIGH: reg_view = {16'h0, fb_high};
         REG_P_GAIN: reg_view = {16'h0, kp};
         REG_I_GAIN: reg_view = {16'h0, ki};
         REG_D_GAIN: reg_view = {16'h0, kd};
         REG_RAMP: reg_view = {20'h0, ramp_rate};
         REG_ALARM_LOW: reg_view = {16'h0, alarm_low};
         REG_ALARM_HIGH: reg_view = {16'h0, alarm_high};
         REG_KEY_SP: reg_view = {20'h0, key_sp};
         REG_KEY_SPEED: reg_view = {20'h0, key_speed};
         REG_PRESET: reg_view = {20'h0, preset_speed};
         REG_STATUS: reg_view = {25'h0, current_input_lost,
            high_level_alarm, low_level_alarm, closed_loop, speed_source};
         REG_SPEED: reg_view = {20'h0, speed_cmd};
         REG_FEEDBACK: reg_view = {16'h0, pv};
         default: reg_view = 32'h0;
      endcase
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= REG_FEEDBACK);
   endfunction

   always_comb begin
      wr_val = reg_view(aw_addr);
      for (int b = 0; b < 4; b++) begin
         if (w_strb[b]) begin
            wr_val[b*8 +: 8] = w_data[b*8 +: 8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write channel: address and data taken in either order
   assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awready && s_axi_awvalid) begin
            s_axi_awready <= 1'b0;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wready && s_axi_wvalid) begin
            s_axi_wready <= 1'b0;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // status, speed and feedback words are read only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= CTRL_RESET;
         fb_low <= FB_LOW_RESET;
         fb_high <= FB_HIGH_RESET;
         kp <= P_GAIN_RESET;
         ki <= 16'h0;
         kd <= 16'h0;
         ramp_rate <= 12'h0;
         alarm_low <= 16'h0;
         alarm_high <= ALARM_HIGH_RESET;
         key_sp <= 12'h0;
         key_speed <= 12'h0;
         preset_speed <= 12'h0;
      end else if (do_write) begin
         case (aw_addr)
            REG_CTRL: ctrl <= wr_val[8:0];
            REG_FB_LOW: fb_low <= wr_val[15:0];
            REG_FB_HIGH: fb_high <= wr_val[15:0];
            REG_P_GAIN: kp <= wr_val[15:0];
            REG_I_GAIN: ki <= wr_val[15:0];
            REG_D_GAIN: kd <= wr_val[15:0];
            REG_RAMP: ramp_rate <= wr_val[11:0];
            REG_ALARM_LOW: alarm_low <= wr_val[15:0];
            REG_ALARM_HIGH: alarm_high <= wr_val[15:0];
            REG_KEY_SP: key_sp <= wr_val[11:0];
            REG_KEY_SPEED: key_speed <= wr_val[11:0];
            REG_PRESET: preset_speed <= wr_val[11:0];
            default: ;
         endcase
      end
   end

   // read channel answers one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arready && s_axi_arvalid) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= reg_view(s_axi_araddr);
         s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // scaling and source selection
   logic [1:0] mode, sp_sel;
   logic loop_on, is_auto, next_closed;
   logic [11:0] cur_q, fb_q, target, sp_src;
   logic [12:0] cur_d, cur_x, fb_n;
   psc_src_t next_src;
   logic signed [31:0] span, mon, fb_w;

   assign mode = ctrl[CTRL_MODE_LSB +: 2];
   assign sp_sel = ctrl[CTRL_SP_SEL_LSB +: 2];
   assign is_auto = ctrl[CTRL_AUTO];
   assign loop_on = (mode == MODE_NORMAL) || (mode == MODE_REVERSE);
   assign next_closed = loop_on && is_auto;
   // set point followed even while open, so closing the loop is bumpless
   assign sp_src = !ctrl[CTRL_REMOTE] ? key_sp
      : (sp_sel == SP_VOLTAGE) ? volt_s
      : (sp_sel == SP_CURRENT) ? cur_q : key_sp;

   always_comb begin
      // 4 mA offset removed, 16 mA span stretched by 5/4 to full scale
      cur_d = (cur_s > CUR_MIN_CODE) ? {1'b0, cur_s - CUR_MIN_CODE} : 13'h0;
      cur_x = cur_d + {2'b00, cur_d[12:2]};
      cur_q = cur_x[12] ? ADC_MAX : cur_x[11:0];
      fb_q = ctrl[CTRL_FB_SEL] ? cur_q : volt_s;
      if (next_closed) begin
         if (ctrl[CTRL_REMOTE] && sp_sel == SP_VOLTAGE) begin
            next_src = SRC_VOLTAGE;
            target = volt_s;
         end else if (ctrl[CTRL_REMOTE] && sp_sel == SP_CURRENT) begin
            next_src = SRC_CURRENT;
            target = cur_q;
         end else begin
            next_src = SRC_KEYPAD_AUTO;
            target = key_sp;
         end
      end else if (!is_auto) begin
         next_src = SRC_KEYPAD_MANUAL;
         target = key_speed;
      end else if (ctrl[CTRL_OL_PRESET]) begin
         next_src = SRC_PRESET;
         target = preset_speed;
      end else if (sp_sel == SP_CURRENT) begin
         next_src = SRC_CURRENT;
         target = cur_q;
      end else begin
         next_src = SRC_VOLTAGE;
         target = volt_s;
      end
   end

   assign span = 32'(fb_high) - 32'(fb_low);
   // full-scale code counts as 4096 so the high value is reached exactly
   assign fb_n = {1'b0, fb_q} + {12'h0, fb_q[11]};
   assign fb_w = 32'(fb_n);
   assign mon = closed_loop ? 32'(pv) : {20'h0, target};

   ////////////////////////////////////////////////////////////////////////
   // sample pulse, one per control period
   logic [31:0] div_cnt;
   logic sample;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt <= 32'h0;
         sample <= 1'b0;
      end else begin
         sample <= (div_cnt == 32'(SAMPLE_CYCLES - 1));
         div_cnt <= (div_cnt == 32'(SAMPLE_CYCLES - 1)) ? 32'h0
            : div_cnt + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // controller arithmetic
   logic [11:0] sp_ramp;
   logic signed [31:0] err, e_prev, p_term, d_term, i_acc, sum;
   logic sat_hi, sat_lo, hold;
   // signed copies keep products and shifts arithmetic for negative error
   logic signed [31:0] kp_w, kd_w, top;

   assign kp_w = {16'h0, kp};
   assign kd_w = {16'h0, kd};
   assign top = {20'h0, ADC_MAX};

   always_comb begin
      err = 32'({1'b0, sp_ramp}) - 32'({1'b0, fb_q});
      if (mode == MODE_REVERSE) begin
         err = -err;
      end
   end
   assign p_term = (kp_w * err) >>> GAIN_FRAC;
   assign d_term = (kd_w * (err - e_prev)) >>> GAIN_FRAC;
   assign sum = p_term + (i_acc >>> INTEG_FRAC) + d_term;
   assign hold = (sat_hi && err > 0) || (sat_lo && err < 0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sp_ramp <= 12'h0;
      end else if (!closed_loop || (sample && ramp_rate == 12'h0)) begin
         sp_ramp <= sp_src;
      end else if (sample) begin
         if (sp_src > sp_ramp) begin
            sp_ramp <= (sp_src - sp_ramp > ramp_rate) ? sp_ramp + ramp_rate
               : sp_src;
         end else begin
            sp_ramp <= (sp_ramp - sp_src > ramp_rate) ? sp_ramp - ramp_rate
               : sp_src;
         end
      end
   end

   // speed command and integral state
   always_ff @(posedge aclk) begin
      if (!aresetn || !closed_loop) begin
         i_acc <= 32'h0;
         e_prev <= 32'h0;
         sat_hi <= 1'b0;
         sat_lo <= 1'b0;
      end else if (sample) begin
         e_prev <= err;
         if (!hold) begin
            i_acc <= i_acc + 32'({16'h0, ki}) * err;
         end
         sat_hi <= sum > top;
         sat_lo <= sum < 0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         speed_cmd <= 12'h0;
      end else if (!closed_loop) begin
         speed_cmd <= target;
      end else if (sample) begin
         if (sum > top) begin
            speed_cmd <= ADC_MAX;
         end else if (sum < 0) begin
            speed_cmd <= 12'h0;
         end else begin
            speed_cmd <= sum[11:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // indications
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         closed_loop <= 1'b0;
         speed_source <= SRC_KEYPAD_MANUAL;
         pv <= 16'h0;
         low_level_alarm <= 1'b0;
         high_level_alarm <= 1'b0;
         current_input_lost <= 1'b0;
      end else begin
         closed_loop <= next_closed;
         speed_source <= next_src;
         pv <= 16'(32'(fb_low) + ((span * fb_w) >>> ADC_W));
         low_level_alarm <= mon < 32'(alarm_low);
         high_level_alarm <= mon > 32'(alarm_high);
         current_input_lost <= ctrl[CTRL_CUR_4_20] && cur_s < CUR_LOSS_CODE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_loop_off;
      @(posedge aclk) disable iff (!aresetn)
      (!loop_on) |=> !closed_loop ##1 (speed_cmd == $past(target));
   endproperty
   a_loop_off: assert property (p_loop_off)
      else $error("loop off did not bypass controller");

   property p_manual_src;
      @(posedge aclk) disable iff (!aresetn)
      (loop_on && !is_auto) |=> (speed_source == SRC_KEYPAD_MANUAL);
   endproperty
   a_manual_src: assert property (p_manual_src)
      else $error("manual mode source code wrong");

   property p_local_src;
      @(posedge aclk) disable iff (!aresetn)
      (next_closed && !ctrl[CTRL_REMOTE]) |=>
         (speed_source == SRC_KEYPAD_AUTO) && closed_loop;
   endproperty
   a_local_src: assert property (p_local_src)
      else $error("local auto source code wrong");

   property p_low_alarm;
      @(posedge aclk) disable iff (!aresetn)
      (mon < 32'(alarm_low)) |=> low_level_alarm;
   endproperty
   a_low_alarm: assert property (p_low_alarm)
      else $error("low alarm missed");

   property p_high_alarm;
      @(posedge aclk) disable iff (!aresetn)
      (mon <= 32'(alarm_high)) |=> !high_level_alarm;
   endproperty
   a_high_alarm: assert property (p_high_alarm)
      else $error("high alarm raised in range");

   property p_loss;
      @(posedge aclk) disable iff (!aresetn)
      (ctrl[CTRL_CUR_4_20] && cur_s < CUR_LOSS_CODE) |=> current_input_lost;
   endproperty
   a_loss: assert property (p_loss)
      else $error("current input loss missed");

   property p_ramp_off;
      @(posedge aclk) disable iff (!aresetn)
      (closed_loop && sample && ramp_rate == 12'h0) |=>
         (sp_ramp == $past(sp_src));
   endproperty
   a_ramp_off: assert property (p_ramp_off)
      else $error("zero ramp rate still ramps");

   property p_clamp;
      @(posedge aclk) disable iff (!aresetn)
      (closed_loop && sample && next_closed && sum > top)
         |=> (speed_cmd == ADC_MAX) && sat_hi;
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("speed command not clamped at maximum");

   property p_integ_clear;
      @(posedge aclk) disable iff (!aresetn)
      (!closed_loop) |=> (i_acc == 32'h0);
   endproperty
   a_integ_clear: assert property (p_integ_clear)
      else $error("integral not cleared while loop open");
endmodule
`default_nettype wire

// [psc_pkg.sv]
// Purpose: shared constants and types of the set point controller
// Assumes: 250 MHz control clock, 12-bit analog converter codes
// Notes: register offsets are byte addresses on the AXI4-Lite slave
package psc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam int CLK_FREQ_MHZ = 250;
   localparam int SAMPLE_PERIOD_US = 1000;
   localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_US * CLK_FREQ_MHZ;

   ////////////////////////////////////////////////////////////////////////
   // analog scaling
   localparam int ADC_W = 12;
   localparam logic [11:0] ADC_MAX = 12'hfff;
   localparam int CUR_FULL_MA = 20;
   localparam int CUR_ZERO_MA = 4;
   localparam int CUR_LOSS_MA = 2;
   localparam logic [11:0] CUR_MIN_CODE =
      12'(4095 * CUR_ZERO_MA / CUR_FULL_MA);
   localparam logic [11:0] CUR_LOSS_CODE =
      12'(4095 * CUR_LOSS_MA / CUR_FULL_MA);
   localparam int GAIN_FRAC = 8;
   localparam int INTEG_FRAC = 16;

   ////////////////////////////////////////////////////////////////////////
   // register map
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_FB_LOW = 8'h04;
   localparam logic [7:0] REG_FB_HIGH = 8'h08;
   localparam logic [7:0] REG_P_GAIN = 8'h0c;
   localparam logic [7:0] REG_I_GAIN = 8'h10;
   localparam logic [7:0] REG_D_GAIN = 8'h14;
   localparam logic [7:0] REG_RAMP = 8'h18;
   localparam logic [7:0] REG_ALARM_LOW = 8'h1c;
   localparam logic [7:0] REG_ALARM_HIGH = 8'h20;
   localparam logic [7:0] REG_KEY_SP = 8'h24;
   localparam logic [7:0] REG_KEY_SPEED = 8'h28;
   localparam logic [7:0] REG_PRESET = 8'h2c;
   localparam logic [7:0] REG_STATUS = 8'h30;
   localparam logic [7:0] REG_SPEED = 8'h34;
   localparam logic [7:0] REG_FEEDBACK = 8'h38;

   // control fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_REMOTE = 2;
   localparam int CTRL_AUTO = 3;
   localparam int CTRL_FB_SEL = 4;
   localparam int CTRL_SP_SEL_LSB = 5;
   localparam int CTRL_OL_PRESET = 7;
   localparam int CTRL_CUR_4_20 = 8;

   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_NORMAL = 2'h1;
   localparam logic [1:0] MODE_REVERSE = 2'h2;
   localparam logic [1:0] SP_VOLTAGE = 2'h0;
   localparam logic [1:0] SP_CURRENT = 2'h1;

   // reset values
   localparam logic [8:0] CTRL_RESET = 9'h100;
   localparam logic [15:0] FB_LOW_RESET = 16'h0000;
   localparam logic [15:0] FB_HIGH_RESET = 16'h0fff;
   localparam logic [15:0] P_GAIN_RESET = 16'h0100;
   localparam logic [15:0] ALARM_HIGH_RESET = 16'h7fff;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      SRC_VOLTAGE,
      SRC_CURRENT,
      SRC_KEYPAD_AUTO,
      SRC_KEYPAD_MANUAL,
      SRC_PRESET
   } psc_src_t;

endpackage

// [psc_sync.sv]
// Purpose: two-stage synchroniser for converter codes from the pins
// Assumes: the converter holds a code stable for several clocks
// Notes: a multi-bit code may tear for one cycle during a change
`timescale 1ns/1ps
`default_nettype none
module psc_sync #(
   parameter int W = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule
`default_nettype wire

// [psc_xducer.sv]
// Purpose: feedback transducer and analog set point source model
// Assumes: bench commands the level each converter should show
// Notes: codes launch just after an edge, like a real converter
`timescale 1ns/1ps
`default_nettype none
module psc_xducer (
   input wire logic aclk,
   input wire logic [11:0] v_lvl,
   input wire logic [11:0] i_lvl,
   output logic [11:0] voltage_input,
   output logic [11:0] current_input
);
   initial begin
      voltage_input = 12'h000;
      current_input = 12'h333;
   end
   // no glitch on the edge itself, so sync stages see a clean code
   always @(posedge aclk) begin
      voltage_input <= v_lvl;
      current_input <= i_lvl;
   end
endmodule
`default_nettype wire

// [tb.sv]
// Purpose: self-checking bench of the set point controller
// Assumes: short sample period; registers over AXI4-Lite
// Notes: end point scaling only, mid-scale rounding is not pinned
`timescale 1ns/1ps
`default_nettype none
module tb;
   import psc_pkg::*;
   localparam int SC = 32;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [31:0] s_axi_rdata, rdv;
   logic [11:0] v_lvl = 12'h000;
   logic [11:0] i_lvl = 12'h333;
   logic [11:0] voltage_input, current_input, speed_cmd;
   psc_src_t speed_source;
   logic closed_loop, low_level_alarm, high_level_alarm;
   logic current_input_lost;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   always #2 aclk = ~aclk;
   psc_controller #(.SAMPLE_CYCLES(SC)) i_dut (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .voltage_input, .current_input, .speed_cmd,
      .speed_source, .closed_loop, .low_level_alarm,
      .high_level_alarm, .current_input_lost);
   psc_xducer i_xd (.aclk, .v_lvl, .i_lvl, .voltage_input,
      .current_input);
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s exp %h got %h", n, e, g);
      end
   endtask
   task summarize;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         summarize();
      end
   end
   // the extra leading edge keeps two transfers from sharing a step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      rr = s_axi_bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      rdv = s_axi_rdata;
      rr = s_axi_rresp;
   endtask
   task automatic st(input int n);
      repeat (n * SC) @(posedge aclk);
   endtask
   task automatic cf(input logic [31:0] c);
      wr(REG_CTRL, c);
      st(4);
   endtask
   ////////////////////////////////////////////////////////////////////
   task t_reset;
      chk("speed", 32'h0, 32'(speed_cmd));
      chk("src", 32'(SRC_KEYPAD_MANUAL), 32'(speed_source));
      chk("closed", 32'h0, 32'(closed_loop));
      rd(REG_CTRL);
      chk("ctrl", 32'h100, rdv);
      rd(REG_FB_HIGH);
      chk("fb_high", 32'h0fff, rdv);
      rd(REG_P_GAIN);
      chk("p_gain", 32'h0100, rdv);
      rd(REG_ALARM_HIGH);
      chk("al_high", 32'h7fff, rdv);
      rd(8'h3c);
      chk("unmapped rresp", 32'(RESP_SLVERR), 32'(rr));
      chk("unmapped rdata", 32'h0, rdv);
      wr(8'h3c, 32'h1);
      chk("unmapped bresp", 32'(RESP_SLVERR), 32'(rr));
      $display("done t_reset");
   endtask
   task t_open;
      wr(REG_KEY_SPEED, 32'h123);
      wr(REG_PRESET, 32'h456);
      v_lvl <= 12'h789;
      cf(32'h100);
      chk("man src", 32'(SRC_KEYPAD_MANUAL), 32'(speed_source));
      chk("man speed", 32'h123, 32'(speed_cmd));
      cf(32'h188);
      chk("pre src", 32'(SRC_PRESET), 32'(speed_source));
      chk("pre speed", 32'h456, 32'(speed_cmd));
      cf(32'h108);
      chk("ana speed", 32'h789, 32'(speed_cmd));
      chk("ana closed", 32'h0, 32'(closed_loop));
      $display("done t_open");
   endtask
   task automatic t_modes;
      // feedback never shares the set point's input type
      logic [31:0] c[5] = '{32'h11d, 32'h12d, 32'h14d, 32'h119,
         32'h145};
      psc_src_t s[5] = '{SRC_VOLTAGE, SRC_CURRENT, SRC_KEYPAD_AUTO,
         SRC_KEYPAD_AUTO, SRC_KEYPAD_MANUAL};
      logic k[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      for (int i = 0; i < 5; i++) begin
         cf(c[i]);
         chk("mode src", 32'(s[i]), 32'(speed_source));
         chk("mode closed", 32'(k[i]), 32'(closed_loop));
      end
      $display("done t_modes");
   endtask
   task t_prop;
      logic seen;
      wr(REG_KEY_SP, 32'h800);
      v_lvl <= 12'h400;
      cf(32'h14d);
      chk("p err", 32'h400, 32'(speed_cmd));
      v_lvl <= 12'h600;
      st(4);
      chk("p rise", 32'h200, 32'(speed_cmd));
      v_lvl <= 12'ha00;
      cf(32'h14e);
      chk("rev high", 32'h200, 32'(speed_cmd));
      v_lvl <= 12'h600;
      st(4);
      chk("rev clamp", 32'h0, 32'(speed_cmd));
      wr(REG_P_GAIN, 32'h400);
      v_lvl <= 12'h400;
      cf(32'h14d);
      chk("top clamp", 32'hfff, 32'(speed_cmd));
      // one sample of error slope shows on the command, then drops to zero
      wr(REG_P_GAIN, 32'h0);
      wr(REG_D_GAIN, 32'h100);
      st(2);
      v_lvl <= 12'h100;
      seen = 1'b0;
      repeat (80) begin
         @(posedge aclk);
         if (speed_cmd == 12'h300) seen = 1'b1;
      end
      chk("d step", 32'h1, 32'(seen));
      wr(REG_D_GAIN, 32'h0);
      v_lvl <= 12'h400;
      $display("done t_prop");
   endtask
   task t_integ;
      wr(REG_P_GAIN, 32'h0);
      wr(REG_I_GAIN, 32'h40);
      cf(32'h100);
      wr(REG_CTRL, 32'h14d);
      st(10);
      chk("i rate", 32'h1, 32'(speed_cmd inside {[8:12]}));
      cf(32'h100);
      wr(REG_CTRL, 32'h14d);
      st(2);
      chk("i clear", 32'h1, 32'(speed_cmd <= 12'h004));
      wr(REG_I_GAIN, 32'h0);
      $display("done t_integ");
   endtask
   task t_ramp;
      wr(REG_P_GAIN, 32'h100);
      wr(REG_KEY_SP, 32'h0);
      v_lvl <= 12'h000;
      // start the ramp from a settled zero with the integral cleared
      cf(32'h100);
      cf(32'h14d);
      wr(REG_RAMP, 32'h40);
      wr(REG_KEY_SP, 32'h400);
      st(3);
      chk("ramp mid", 32'h1, 32'(speed_cmd inside {[1:12'h3ff]}));
      st(20);
      chk("ramp end", 32'h400, 32'(speed_cmd));
      wr(REG_RAMP, 32'h0);
      $display("done t_ramp");
   endtask
   task t_scale;
      wr(REG_FB_LOW, 32'h64);
      wr(REG_FB_HIGH, 32'h44c);
      cf(32'h15d);
      rd(REG_FEEDBACK);
      chk("fb at 4ma", 32'h64, rdv);
      i_lvl <= 12'hfff;
      st(1);
      rd(REG_FEEDBACK);
      chk("fb at 20ma", 32'h44c, rdv);
      // sensor that falls as the process rises
      wr(REG_FB_LOW, 32'h44c);
      wr(REG_FB_HIGH, 32'h64);
      st(1);
      rd(REG_FEEDBACK);
      chk("fb swapped", 32'h64, rdv);
      i_lvl <= 12'h100;
      st(1);
      chk("lost", 32'h1, 32'(current_input_lost));
      cf(32'h05d);
      chk("lost 0-20", 32'h0, 32'(current_input_lost));
      i_lvl <= 12'h333;
      wr(REG_FB_LOW, 32'h0);
      wr(REG_FB_HIGH, 32'hfff);
      $display("done t_scale");
   endtask
   task automatic t_alarm;
      logic [11:0] sp[3] = '{12'h100, 12'h300, 12'h500};
      logic lo[3] = '{1'b1, 1'b0, 1'b0};
      logic hi[3] = '{1'b0, 1'b0, 1'b1};
      wr(REG_ALARM_LOW, 32'h200);
      wr(REG_ALARM_HIGH, 32'h400);
      cf(32'h100);
      for (int i = 0; i < 3; i++) begin
         wr(REG_KEY_SPEED, 32'(sp[i]));
         st(1);
         chk("low alarm", 32'(lo[i]), 32'(low_level_alarm));
         chk("high alarm", 32'(hi[i]), 32'(high_level_alarm));
      end
      $display("done t_alarm");
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_open();
      t_modes();
      t_prop();
      t_integ();
      t_ramp();
      t_scale();
      t_alarm();
      summarize();
   end
endmodule
`default_nettype wire
